// [logic/dioport_regs.vh]
// Register offsets, field positions and reset values of the dual I/O port block.
// Operation
// - First port output muxes peripheral over latch.
// - Peripheral enable only when selected; else direction.
// - First direction at 87h resets all ones.
// - Second port eight pins, each direction independent.
// - Mode bit four makes second port slave.
// - First pin three selectable serial clock.
// - First pin four serial data in or I2C.
// - First pin five general or serial out.
// - First pin two general or capture/compare/PWM one.
// - Pins six/seven selectable for USART functions.
// - Pins zero/one timer oscillator; zero clock input.
// - Pin one also second capture/compare/PWM unit.
// - Second pin n carries slave data bit n.
// - Second data 08h, direction 88h, ones reset.
// - Data latches undefined at power-on, kept otherwise; here power-on clears them to 00h.
// - Shared control 89h resets 07h, bit3 zero.
// - Direction one tristates; zero drives latch.
// - Data read returns pins; write sets latch.
// - Peripheral may force pin direction regardless.
`ifndef DIOPORT_REGS_VH
`define DIOPORT_REGS_VH
`define DIOP_ADDR_C_DATA    8'h07
`define DIOP_ADDR_D_DATA    8'h08
`define DIOP_ADDR_C_DIR     8'h87
`define DIOP_ADDR_D_DIR     8'h88
`define DIOP_ADDR_SHARED    8'h89
`define DIOP_RST_DIR        8'hFF
`define DIOP_RST_SHARED     8'h07
`define DIOP_SHARED_WMASK   8'h17
`define DIOP_BIT_MODE       4
`define DIOP_RST_LATCH      8'h00
`endif

// [logic/dioport_sync.v]
// Three-stage input synchroniser that accepts a change once stages two and three agree.
module dioport_sync #(
  parameter W = 8
) (
  input  wire         sys_clk,
  input  wire         arst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;

  // Stage one feeds only stage two, so no logic sees a metastable value.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Each bit updates only when the two settled stages agree.
  generate
    for (i = 0; i < W; i = i + 1) begin : g_flt
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          dout[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule // dioport_sync

// [logic/dioport_top.v]
// Two eight-bit I/O ports with peripheral override and a parallel slave data mode.
`include "dioport_regs.vh"
module dioport_top (
  input  wire       sys_clk,
  input  wire       arst_n,
  input  wire       por_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] first_port_in,
  output reg  [7:0] first_port_out,
  output reg  [7:0] first_port_oe,
  input  wire [7:0] second_port_in,
  output reg  [7:0] second_port_out,
  output reg  [7:0] second_port_oe,
  input  wire [7:0] periph_sel,
  input  wire [7:0] periph_out,
  input  wire [7:0] periph_oe,
  output reg  [7:0] periph_in,
  output reg  [7:0] parallel_slave_data_in,
  input  wire [7:0] parallel_slave_data_out,
  input  wire       parallel_slave_drive,
  input  wire [2:0] slave_status,
  output reg        slave_port_mode_bit,
  output reg  [2:0] third_port_dir
);
  // Per-pin peripheral roles on the first port (periph_sel bit n selects pin n):
  // 0 secondary_timer_osc_in / secondary_timer_clock_in, 1 secondary_timer_osc_out or
  // capture_compare_pwm_two, 2 capture_compare_pwm_one, 3 serial clock, 4 serial data in or
  // I2C data, 5 serial data out, 6 USART transmit/clock, 7 USART receive/data.

  reg  [7:0] c_lat_r;
  reg  [7:0] c_dir_r;
  reg  [7:0] d_lat_r;
  reg  [7:0] d_dir_r;
  reg  [7:0] shared_r;
  reg  [7:0] rdata_nxt;
  reg  [7:0] c_out_nxt;
  reg  [7:0] c_oe_nxt;
  wire [7:0] c_pins;
  wire [7:0] d_pins;
  wire       mode;
  integer    k;

  assign mode = shared_r[`DIOP_BIT_MODE];

  // Pins cross into the clock domain before anything reads them.
  dioport_sync #(.W(8)) u_sync_c (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (first_port_in),
    .dout    (c_pins)
  );
  dioport_sync #(.W(8)) u_sync_d (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (second_port_in),
    .dout    (d_pins)
  );

  // Latches have no true unknown in silicon; power-on clears them, other resets keep them.
  always @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      c_lat_r <= `DIOP_RST_LATCH;
      d_lat_r <= `DIOP_RST_LATCH;
    end else begin
      if (reg_wr && reg_addr == `DIOP_ADDR_C_DATA) begin
        c_lat_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `DIOP_ADDR_D_DATA) begin
        d_lat_r <= reg_wdata;
      end
    end
  end

  // Direction and control registers reset on every reset.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      c_dir_r  <= `DIOP_RST_DIR;
      d_dir_r  <= `DIOP_RST_DIR;
      shared_r <= `DIOP_RST_SHARED;
    end else begin
      if (reg_wr && reg_addr == `DIOP_ADDR_C_DIR) begin
        c_dir_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `DIOP_ADDR_D_DIR) begin
        d_dir_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `DIOP_ADDR_SHARED) begin
        shared_r <= reg_wdata & `DIOP_SHARED_WMASK;
      end
    end
  end

  // Read mux: data addresses return pin levels; unmapped addresses read zero.
  always @* begin
    case (reg_addr)
      `DIOP_ADDR_C_DATA: rdata_nxt = c_pins;
      `DIOP_ADDR_D_DATA: rdata_nxt = d_pins;
      `DIOP_ADDR_C_DIR:  rdata_nxt = c_dir_r;
      `DIOP_ADDR_D_DIR:  rdata_nxt = d_dir_r;
      `DIOP_ADDR_SHARED: rdata_nxt = {slave_status, shared_r[4], 1'b0, shared_r[2:0]};
      default:           rdata_nxt = 8'h00;
    endcase
  end

  // First port: peripheral takes both data and enable of a pin only while selected.
  always @* begin
    c_out_nxt = 8'h00;
    c_oe_nxt  = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      if (periph_sel[k]) begin
        c_out_nxt[k] = periph_out[k];
        c_oe_nxt[k]  = periph_oe[k];
      end else begin
        c_out_nxt[k] = c_lat_r[k];
        c_oe_nxt[k]  = ~c_dir_r[k];
      end
    end
  end

  // Outputs are registered, costing a cycle of pin latency for glitch-free drive.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata              <= 8'h00;
      first_port_out         <= 8'h00;
      first_port_oe          <= 8'h00;
      second_port_out        <= 8'h00;
      second_port_oe         <= 8'h00;
      periph_in              <= 8'h00;
      parallel_slave_data_in <= 8'h00;
      slave_port_mode_bit    <= 1'b0;
      third_port_dir         <= 3'h7;
    end else begin
      reg_rdata      <= reg_rd ? rdata_nxt : 8'h00;
      first_port_out <= c_out_nxt;
      first_port_oe  <= c_oe_nxt;
      periph_in      <= c_pins;
      if (mode) begin
        second_port_out <= parallel_slave_data_out;
        second_port_oe  <= {8{parallel_slave_drive}};
      end else begin
        second_port_out <= d_lat_r;
        second_port_oe  <= ~d_dir_r;
      end
      parallel_slave_data_in <= d_pins;
      slave_port_mode_bit    <= mode;
      third_port_dir         <= shared_r[2:0];
    end
  end
endmodule // dioport_top

// [dv/diop_pin_model.sv]
// Model of the outside circuitry that shares the pins of both ports.
module diop_pin_model (
  input  wire [7:0] drv_out,
  input  wire [7:0] drv_oe,
  input  wire [7:0] ext_val,
  output wire [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin shows the outside level, chosen by the bench to differ from the latch.
  assign pin = (drv_oe & drv_out) | (~drv_oe & ext_val);
endmodule // diop_pin_model

// [dv/diop_properties.sv]
// Port-level assertions for the dual I/O port block.
module diop_properties (
  input wire       sys_clk,
  input wire       arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] first_port_out,
  input wire [7:0] first_port_oe,
  input wire [7:0] second_port_oe,
  input wire [7:0] periph_sel,
  input wire [7:0] periph_out,
  input wire [7:0] periph_oe,
  input wire       parallel_slave_drive,
  input wire       slave_port_mode_bit,
  input wire [2:0] third_port_dir
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // A write to the shared control register is the first step of the mode change.
  sequence s_shared_wr;
    reg_wr && reg_addr == 8'h89;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  a_unmapped_read: assert property ($past(reg_rd && !(reg_addr inside
    {8'h07, 8'h08, 8'h87, 8'h88, 8'h89})) |-> reg_rdata == 8'h00) else $error("unmapped data");
  a_shared_bit3: assert property ($past(reg_rd && reg_addr == 8'h89) |-> !reg_rdata[3])
    else $error("bit3 set");
  a_shared_copy: assert property (s_shared_wr |-> ##2 {slave_port_mode_bit, third_port_dir} ==
    $past({reg_wdata[4], reg_wdata[2:0]}, 2)) else $error("shared copy wrong");
  a_sel_out: assert property (((first_port_out ^ $past(periph_out)) & $past(periph_sel)) == 8'h00)
    else $error("peripheral data lost");
  a_sel_oe: assert property (((first_port_oe ^ $past(periph_oe)) & $past(periph_sel)) == 8'h00)
    else $error("peripheral enable lost");
  a_slave_drive: assert property (slave_port_mode_bit && $past(parallel_slave_drive) |->
    second_port_oe == 8'hFF) else $error("slave bus not driven");
  a_slave_float: assert property (slave_port_mode_bit && !$past(parallel_slave_drive) |->
    second_port_oe == 8'h00) else $error("slave bus not released");
endmodule // diop_properties
bind dioport_top diop_properties diop_properties_i (.sys_clk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .first_port_out, .first_port_oe, .second_port_oe, .periph_sel,
  .periph_out, .periph_oe, .parallel_slave_drive, .slave_port_mode_bit, .third_port_dir);

// [dv/tb.sv]
// Self-checking bench for the dual I/O port block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, arst_n, por_n, wr_s, rd_s, psd_drv;
  logic [7:0] addr, wdat, sel, p_out, p_oe, psd_out, c_ext, d_ext;
  logic [2:0] status;
  wire  [7:0] rdat, c_out, c_oe, d_out, d_oe, c_pin, d_pin, psd_in, p_in;
  wire        mode;
  wire  [2:0] e_dir;
  int         bad_count, cmp_count;
  dioport_top dioport_top_i (.sys_clk, .arst_n, .por_n, .reg_addr(addr), .reg_wdata(wdat),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .first_port_in(c_pin), .first_port_out(c_out),
    .first_port_oe(c_oe), .second_port_in(d_pin), .second_port_out(d_out), .second_port_oe(d_oe),
    .periph_sel(sel), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
    .parallel_slave_data_in(psd_in), .parallel_slave_data_out(psd_out),
    .parallel_slave_drive(psd_drv), .slave_status(status), .slave_port_mode_bit(mode),
    .third_port_dir(e_dir));
  diop_pin_model diop_pin_model_i (.drv_out(c_out), .drv_oe(c_oe), .ext_val(c_ext), .pin(c_pin));
  diop_pin_model diop_pin_model_d_i (.drv_out(d_out), .drv_oe(d_oe), .ext_val(d_ext), .pin(d_pin));
  // Free-running core clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles launch just after an edge, so a gap cycle separates them.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 chk("reg_rdata", e, rdat);
  endtask
  // Outputs are looked at 1 ns past an edge, where they have settled.
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rst(input logic p);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    por_n <= p;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_first();
    rc(8'h87, 8'hFF);
    chk("first_port_oe", 8'h00, c_oe);
    wr(8'h07, 8'h00);
    wr(8'h07, 8'hA5);
    wr(8'h87, 8'h0F);
    w(2);
    chk("first_port_out", 8'hA5, c_out);
    chk("first_port_oe", 8'hF0, c_oe);
    w(4);
    chk("periph_in", 8'hAC, p_in);
    rc(8'h07, 8'hAC);
    @(posedge sys_clk);
    sel <= 8'hFF;
    p_out <= 8'h69;
    p_oe <= 8'h0F;
    w(2);
    chk("first_port_out", 8'h69, c_out);
    chk("first_port_oe", 8'h0F, c_oe);
    @(posedge sys_clk);
    sel <= 8'h00;
  endtask
  task automatic t_second();
    rc(8'h88, 8'hFF);
    wr(8'h88, 8'hF0);
    wr(8'h08, 8'h5A);
    w(6);
    chk("second_port_oe", 8'h0F, d_oe);
    rc(8'h08, 8'hCA);
    rc(8'h89, 8'hA7);
    wr(8'h89, 8'hFF);
    w(2);
    chk("shared_copy", 8'h0F, {4'h0, mode, e_dir});
    rc(8'h89, 8'hB7);
    @(posedge sys_clk);
    psd_drv <= 1'b1;
    psd_out <= 8'h96;
    w(6);
    chk("second_port_out", 8'h96, d_out);
    chk("parallel_slave_data_in", 8'h96, psd_in);
    @(posedge sys_clk);
    psd_drv <= 1'b0;
    w(6);
    chk("parallel_slave_data_in", 8'hC3, psd_in);
    wr(8'h42, 8'h55);
    rc(8'h42, 8'h00);
  endtask
  task automatic t_reset();
    rst(1'b1);
    rc(8'h89, 8'hA7);
    wr(8'h87, 8'h00);
    w(2);
    chk("first_port_out", 8'hA5, c_out);
    rst(1'b0);
    wr(8'h87, 8'h00);
    w(2);
    chk("first_port_out", 8'h00, c_out);
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    {arst_n, por_n, wr_s, rd_s, psd_drv} = '0;
    {addr, wdat, sel, p_out, p_oe, psd_out} = '0;
    c_ext = 8'h3C;
    d_ext = 8'hC3;
    status = 3'h5;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    t_first();
    t_second();
    t_reset();
    print_verdict();
  end
  // Watchdog far beyond the fewer than a hundred cycles the scenarios take.
  initial begin
    #50000;
    bad_count++;
    print_verdict();
  end
endmodule // tb
